// File: core/pdm_amp_ctrl.sv
// Control logic of a pulse-density input amplifier: strap latch, pattern detector, power control.
// Assumes link wires and supply/strap pins are asynchronous to aclk and the link clock is far slower.
//
// Notes on behaviour
// - Strap sampled once when supply comes up.
// - Smart mode: 128 stop bytes give standby.
// - Clock stopped in standby means full power-down.
// - Clock back plus non-stop byte wakes.
// - Low supply holds all logic in reset.
// - Supply drop stops output, asserts reset.
// - Strap: weak gives 5V gain, high 64x.
// - Patterns change gain and rate at runtime.
// - Separate decimation setting for each rate.
// - Source should prefer 64x rate.
// - Commands are repeated 8-bit patterns.
// - Pattern accepted after 128 repetitions.
// - Output muted while a pattern is seen.
// - Clock loss restores all pattern defaults.
// - Stop pattern powers down, normal start-up.
// - D8/D4/D2 override gain 5V/3.6V/2.5V.
// - D1 inverts the strap rate.
// - E1 selects low-emission modulation.
// - E2 selects half-cycle pulse mode.
// - E4 selects 32 kHz at 128x mode.
// - Source clock synchronous, in allowed bands.
// - Channel strap picks right or left edge.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module pdm_amp_ctrl #(
    parameter logic [15:0] LOSS_LIMIT    = pdm_ctrl_pkg::LOSS_CYC,
    parameter logic [15:0] STARTUP_LIMIT = pdm_ctrl_pkg::STARTUP_CYC
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    pdm_link_if.sink             link,
    input  wire logic            power_stage_supply_ok,
    input  wire logic            logic_supply_ok,
    input  wire logic            gain_rate_strap_high,
    input  wire logic            gain_rate_strap_weak,
    input  wire logic            channel_side_strap,
    input  wire logic            smart_pd_enable,
    output logic                 internal_reset_n,
    output pdm_ctrl_pkg::gain_t  gain_sel,
    output logic                 rate_128,
    output logic                 decim_128,
    output logic                 low_emission,
    output logic                 half_pulse,
    output logic                 mode_32k,
    output logic                 mute,
    output logic                 standby,
    output logic                 full_power_down,
    output logic                 output_enable,
    output logic                 audio_bit,
    output logic                 audio_valid
);
    // --------
    // Input synchronisers
    // --------
    logic [6:0] pins_s;

    sync2 #(.W(7)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({link.bit_clk, link.data, power_stage_supply_ok, logic_supply_ok,
                   gain_rate_strap_high, gain_rate_strap_weak, channel_side_strap}),
        .dout    (pins_s)
    );

    logic clk_s;
    logic data_s;
    logic supplies_ok;
    logic strap_high_s;
    logic strap_weak_s;
    logic right_s;
    logic rst_int;

    assign clk_s        = pins_s[6];
    assign data_s       = pins_s[5];
    assign supplies_ok  = pins_s[4] & pins_s[3];
    assign strap_high_s = pins_s[2];
    assign strap_weak_s = pins_s[1];
    assign right_s      = pins_s[0];
    assign rst_int      = !aresetn || !supplies_ok;

    // --------
    // State
    // --------
    typedef struct packed {
        logic                      rst_n;
        logic                      clk_d;
        logic [7:0]                win;
        logic [2:0]                bit_cnt;
        logic [15:0]               per_cnt;
        logic [15:0]               idle_cnt;
        logic [15:0]               start_cnt;
        pdm_ctrl_pkg::pwr_state_t  st;
        logic                      taken;
        logic                      strap_128;
        pdm_ctrl_pkg::gain_t       strap_gain;
        logic                      ovr_on;
        pdm_ctrl_pkg::gain_t       ovr_gain;
        logic                      rate_flip;
        logic                      low_em;
        logic                      half_p;
        logic                      m32k;
        pdm_ctrl_pkg::gain_t       gain_q;
        logic                      rate_q;
        logic                      mute;
        logic                      oe;
        logic                      abit;
        logic                      avalid;
    } amp_state_t;

    localparam amp_state_t RESET_STATE = '{
        st:         pdm_ctrl_pkg::PS_RUN,
        strap_gain: pdm_ctrl_pkg::GAIN_5V,
        ovr_gain:   pdm_ctrl_pkg::GAIN_5V,
        gain_q:     pdm_ctrl_pkg::GAIN_5V,
        default:    '0
    };

    amp_state_t s_reg;
    amp_state_t s_next;

    always_comb begin
        logic any_edge;
        logic smp_edge;
        any_edge     = s_reg.clk_d != clk_s;
        smp_edge     = any_edge && (clk_s != right_s);
        s_next        = s_reg;
        s_next.rst_n  = 1'b1;
        s_next.clk_d  = clk_s;
        s_next.avalid = 1'b0;

        if (!s_reg.taken) begin
            s_next.taken      = 1'b1;
            s_next.strap_128  = !strap_high_s;
            s_next.strap_gain = strap_weak_s ? pdm_ctrl_pkg::GAIN_5V : pdm_ctrl_pkg::GAIN_3V6;
        end

        // Clock-loss watchdog
        if (any_edge) begin
            s_next.idle_cnt = '0;
        end else if (s_reg.idle_cnt != LOSS_LIMIT) begin
            s_next.idle_cnt = s_reg.idle_cnt + 16'h0001;
        end

        if (smp_edge) begin
            s_next.abit    = data_s;
            s_next.avalid  = 1'b1;
            s_next.win     = {s_reg.win[6:0], data_s};
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            // Bit matching one word back extends the run
            if (data_s == s_reg.win[7]) begin
                if (s_reg.per_cnt != 16'hFFFF) begin
                    s_next.per_cnt = s_reg.per_cnt + 16'h0001;
                end
            end else begin
                s_next.per_cnt = '0;
            end

            if (s_next.per_cnt >= pdm_ctrl_pkg::DETECT_BITS) begin
                case (s_next.win)
                    pdm_ctrl_pkg::PAT_STOP: begin
                        if (smart_pd_enable && s_reg.st == pdm_ctrl_pkg::PS_RUN) begin
                            s_next.st = pdm_ctrl_pkg::PS_STANDBY;
                        end
                    end
                    pdm_ctrl_pkg::PAT_GAIN_5V: begin
                        s_next.ovr_on   = 1'b1;
                        s_next.ovr_gain = pdm_ctrl_pkg::GAIN_5V;
                    end
                    pdm_ctrl_pkg::PAT_GAIN_3V6: begin
                        s_next.ovr_on   = 1'b1;
                        s_next.ovr_gain = pdm_ctrl_pkg::GAIN_3V6;
                    end
                    pdm_ctrl_pkg::PAT_GAIN_2V5: begin
                        s_next.ovr_on   = 1'b1;
                        s_next.ovr_gain = pdm_ctrl_pkg::GAIN_2V5;
                    end
                    pdm_ctrl_pkg::PAT_RATE_ALT: s_next.rate_flip = 1'b1;
                    pdm_ctrl_pkg::PAT_LOW_EMI:  s_next.low_em    = 1'b1;
                    pdm_ctrl_pkg::PAT_HALF_PLS: s_next.half_p    = 1'b1;
                    pdm_ctrl_pkg::PAT_FS32K:    s_next.m32k      = 1'b1;
                    default: ;
                endcase
            end

            // Fresh non-stop byte wakes the part
            if (s_reg.st != pdm_ctrl_pkg::PS_RUN && s_reg.bit_cnt == pdm_ctrl_pkg::LAST_BIT
                && !pdm_ctrl_pkg::is_stop_rot(s_next.win)) begin
                s_next.st        = pdm_ctrl_pkg::PS_RUN;
                s_next.start_cnt = '0;
            end
        end

        if (s_next.idle_cnt == LOSS_LIMIT) begin
            s_next.st        = pdm_ctrl_pkg::PS_OFF;
            s_next.bit_cnt   = '0;
            s_next.per_cnt   = '0;
            s_next.start_cnt = '0;
            s_next.ovr_on    = 1'b0;
            s_next.ovr_gain  = pdm_ctrl_pkg::GAIN_5V;
            s_next.rate_flip = 1'b0;
            s_next.low_em    = 1'b0;
            s_next.half_p    = 1'b0;
            s_next.m32k      = 1'b0;
        end

        if (s_next.st == pdm_ctrl_pkg::PS_RUN && s_next.start_cnt != STARTUP_LIMIT) begin
            s_next.start_cnt = s_next.start_cnt + 16'h0001;
        end

        s_next.gain_q = s_next.ovr_on ? s_next.ovr_gain : s_next.strap_gain;
        s_next.rate_q = s_next.strap_128 ^ s_next.rate_flip;
        s_next.mute   = s_next.per_cnt >= pdm_ctrl_pkg::MUTE_BITS;
        s_next.oe     = s_next.st == pdm_ctrl_pkg::PS_RUN && s_next.start_cnt == STARTUP_LIMIT
                        && !s_next.mute;
    end

    always_ff @(posedge aclk) begin
        if (rst_int) begin
            s_reg <= RESET_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    // --------
    // Outputs
    // --------
    assign internal_reset_n = s_reg.rst_n;
    assign gain_sel         = s_reg.gain_q;
    assign rate_128         = s_reg.rate_q;
    assign decim_128        = s_reg.rate_q;
    assign low_emission     = s_reg.low_em;
    assign half_pulse       = s_reg.half_p;
    assign mode_32k         = s_reg.m32k;
    assign mute             = s_reg.mute;
    assign standby          = s_reg.st == pdm_ctrl_pkg::PS_STANDBY;
    assign full_power_down  = s_reg.st == pdm_ctrl_pkg::PS_OFF;
    assign output_enable    = s_reg.oe;
    assign audio_bit        = s_reg.abit;
    assign audio_valid      = s_reg.avalid;
endmodule : pdm_amp_ctrl

// File: core/pdm_ctrl_pkg.sv
// Shared constants and types for the pulse-density link, its sink and its source.
// Assumes a 50 MHz system clock on both ends.
package pdm_ctrl_pkg;

    // --------
    // Timing
    // --------
    localparam int CLK_PERIOD_NS  = 20;
    localparam int LINK_PERIOD_NS = 160;
    localparam int LOSS_NS        = 2000;
    localparam int STARTUP_NS     = 10000;
    localparam logic [15:0] LINK_HALF_CYC = 16'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [15:0] LOSS_CYC      = 16'((LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] STARTUP_CYC   = 16'((STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // --------
    // Pattern control
    // --------
    localparam int BYTE_BITS  = 8;
    localparam int REPEAT_MIN = 128;
    localparam logic [15:0] DETECT_BITS = 16'((REPEAT_MIN - 1) * BYTE_BITS);
    localparam logic [15:0] MUTE_BITS   = 16'(BYTE_BITS);
    localparam logic [2:0]  LAST_BIT    = 3'(BYTE_BITS - 1);
    localparam logic [7:0] PAT_STOP     = 8'hAC;
    localparam logic [7:0] PAT_GAIN_5V  = 8'hD8;
    localparam logic [7:0] PAT_GAIN_3V6 = 8'hD4;
    localparam logic [7:0] PAT_GAIN_2V5 = 8'hD2;
    localparam logic [7:0] PAT_RATE_ALT = 8'hD1;
    localparam logic [7:0] PAT_LOW_EMI  = 8'hE1;
    localparam logic [7:0] PAT_HALF_PLS = 8'hE2;
    localparam logic [7:0] PAT_FS32K    = 8'hE4;

    typedef enum logic [1:0] {
        GAIN_5V  = 2'h0,
        GAIN_3V6 = 2'h1,
        GAIN_2V5 = 2'h2
    } gain_t;

    typedef enum logic [2:0] {
        PS_RUN     = 3'h1,
        PS_STANDBY = 3'h2,
        PS_OFF     = 3'h4
    } pwr_state_t;

    // --------
    // Source controller registers
    // --------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_AUDIO  = 8'h04;
    localparam logic [7:0] REG_CMD    = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_RIGHT_BIT = 1;
    localparam int CMD_HOLD_BIT   = 8;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_RUN_BIT   = 1;
    localparam int STAT_CNT_LSB   = 16;
    localparam logic [7:0] AUDIO_RST = 8'h96;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // True when w is any rotation of the stop pattern
    function automatic logic is_stop_rot(input logic [7:0] w);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < BYTE_BITS; i++) begin
            if (w == 8'({PAT_STOP, PAT_STOP} >> i)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : is_stop_rot

endpackage : pdm_ctrl_pkg

// File: core/pdm_link_if.sv
// Pulse-density link between source and amplifier control.
// Assumes the source drives both wires.
`timescale 1ns/1ps
interface pdm_link_if;
    logic bit_clk;
    logic data;

    modport source (output bit_clk, output data);
    modport sink   (input  bit_clk, input  data);
endinterface : pdm_link_if

// File: core/sync2.sv
// Two-flop synchroniser for a bundle of levels.
// Assumes inputs are quasi-static levels or slow clocks.
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    always_comb begin
        s_next    = s_reg;
        s_next.s1 = din;
        s_next.s2 = s_reg.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.s2;
endmodule : sync2

// File: core/pdm_source_ctrl.sv
// Pulse-density source: drives bit clock and data, sends repeated control patterns.
// Assumes software on AXI4-Lite; link clock derived here by a divider of aclk.
`timescale 1ns/1ps
module pdm_source_ctrl #(
    parameter logic [15:0] HALF_CYC    = pdm_ctrl_pkg::LINK_HALF_CYC,
    parameter logic [15:0] CMD_REPEATS = 16'(pdm_ctrl_pkg::REPEAT_MIN + 2)
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    pdm_link_if.source       link,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef struct packed {
        logic        clk_o;
        logic        data_o;
        logic [15:0] half_cnt;
        logic [2:0]  bit_idx;
        logic [7:0]  word;
        logic        inv;
        logic        run;
        logic        right;
        logic [7:0]  audio;
        logic        cmd_on;
        logic        cmd_hold;
        logic [7:0]  cmd_byte;
        logic [15:0] rep_cnt;
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } src_state_t;

    localparam src_state_t RESET_STATE = '{
        bit_idx: pdm_ctrl_pkg::LAST_BIT,
        audio:   pdm_ctrl_pkg::AUDIO_RST,
        default: '0
    };

    src_state_t s_reg;
    src_state_t s_next;

    always_comb begin
        s_next = s_reg;

        // --------
        // Clock divider and bit launch
        // --------
        if (s_reg.run || s_reg.clk_o) begin
            if (s_reg.half_cnt == HALF_CYC - 16'h0001) begin
                s_next.half_cnt = '0;
                s_next.clk_o    = !s_reg.clk_o;
                // Launch opposite the sampling edge
                if (s_next.clk_o == s_reg.right) begin
                    s_next.data_o = s_reg.word[s_reg.bit_idx] ^ (s_reg.inv && !s_reg.cmd_on);
                    if (s_reg.bit_idx == 3'h0) begin
                        s_next.bit_idx = pdm_ctrl_pkg::LAST_BIT;
                        s_next.inv     = !s_reg.inv;
                        if (s_reg.cmd_on) begin
                            s_next.rep_cnt = s_reg.rep_cnt + 16'h0001;
                            if (s_next.rep_cnt >= CMD_REPEATS && !s_reg.cmd_hold) begin
                                s_next.cmd_on = 1'b0;
                            end
                        end
                        s_next.word = s_next.cmd_on ? s_reg.cmd_byte : s_reg.audio;
                    end else begin
                        s_next.bit_idx = s_reg.bit_idx - 3'h1;
                    end
                end
            end else begin
                s_next.half_cnt = s_reg.half_cnt + 16'h0001;
            end
        end

        // --------
        // AXI4-Lite write
        // --------
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_have = 1'b1;
            s_next.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_have = 1'b1;
            s_next.wdata  = s_axi_wdata;
            s_next.wstrb  = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
            s_next.aw_have = 1'b0;
            s_next.w_have  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = pdm_ctrl_pkg::RESP_OKAY;
            if (s_reg.awaddr == pdm_ctrl_pkg::REG_CTRL) begin
                if (s_reg.wstrb[0]) begin
                    s_next.run   = s_reg.wdata[pdm_ctrl_pkg::CTRL_RUN_BIT];
                    s_next.right = s_reg.wdata[pdm_ctrl_pkg::CTRL_RIGHT_BIT];
                end
            end else if (s_reg.awaddr == pdm_ctrl_pkg::REG_AUDIO) begin
                if (s_reg.wstrb[0]) begin
                    s_next.audio = s_reg.wdata[7:0];
                end
            end else if (s_reg.awaddr == pdm_ctrl_pkg::REG_CMD) begin
                if (s_reg.wstrb[0]) begin
                    s_next.cmd_on   = 1'b1;
                    s_next.cmd_byte = s_reg.wdata[7:0];
                    s_next.cmd_hold = s_reg.wdata[pdm_ctrl_pkg::CMD_HOLD_BIT];
                    s_next.rep_cnt  = '0;
                end
            end else if (s_reg.awaddr != pdm_ctrl_pkg::REG_STATUS) begin
                s_next.bresp = pdm_ctrl_pkg::RESP_SLVERR;
            end
        end

        // --------
        // AXI4-Lite read
        // --------
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = '0;
            s_next.rresp  = pdm_ctrl_pkg::RESP_OKAY;
            if (s_axi_araddr == pdm_ctrl_pkg::REG_CTRL) begin
                s_next.rdata[pdm_ctrl_pkg::CTRL_RUN_BIT]   = s_reg.run;
                s_next.rdata[pdm_ctrl_pkg::CTRL_RIGHT_BIT] = s_reg.right;
            end else if (s_axi_araddr == pdm_ctrl_pkg::REG_AUDIO) begin
                s_next.rdata[7:0] = s_reg.audio;
            end else if (s_axi_araddr == pdm_ctrl_pkg::REG_CMD) begin
                s_next.rdata[7:0]                        = s_reg.cmd_byte;
                s_next.rdata[pdm_ctrl_pkg::CMD_HOLD_BIT] = s_reg.cmd_hold;
            end else if (s_axi_araddr == pdm_ctrl_pkg::REG_STATUS) begin
                s_next.rdata[pdm_ctrl_pkg::STAT_BUSY_BIT] = s_reg.cmd_on;
                s_next.rdata[pdm_ctrl_pkg::STAT_RUN_BIT]  = s_reg.run || s_reg.clk_o;
                s_next.rdata[31:pdm_ctrl_pkg::STAT_CNT_LSB] = s_reg.rep_cnt;
            end else begin
                s_next.rresp = pdm_ctrl_pkg::RESP_SLVERR;
            end
        end

        s_next.awready = !s_next.aw_have && !s_next.bvalid;
        s_next.wready  = !s_next.w_have && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= RESET_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.bit_clk  = s_reg.clk_o;
    assign link.data     = s_reg.data_o;
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready  = s_reg.wready;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rdata   = s_reg.rdata;
    assign s_axi_rresp   = s_reg.rresp;
endmodule : pdm_source_ctrl

// File: sim/pdm_link_props.sv
// Checker on the link wires and the amplifier control outputs.
// Assumes one aclk domain and a link half period of four aclk cycles.
`timescale 1ns/1ps
module pdm_link_props (
    input wire logic           aclk,
    input wire logic           aresetn,
    input wire logic           bit_clk,
    input wire logic           data,
    input wire logic           smart_pd_enable,
    input wire logic           internal_reset_n,
    input pdm_ctrl_pkg::gain_t gain_sel,
    input wire logic           rate_128,
    input wire logic           decim_128,
    input wire logic           low_emission,
    input wire logic           half_pulse,
    input wire logic           mode_32k,
    input wire logic           mute,
    input wire logic           standby,
    input wire logic           full_power_down,
    input wire logic           output_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       prev_reg;
    logic [7:0] idle_reg;
    // Saturating idle count of bit clock
    always_ff @(posedge aclk) begin
        prev_reg <= bit_clk;
        idle_reg <= (!aresetn || bit_clk != prev_reg) ? 8'h00 : idle_reg + {7'h00, idle_reg != 8'hFF};
    end
    oe_mute_a: assert property (mute && $past(mute) |-> !output_enable)
        else $error("Enabled while muted");
    oe_standby_a: assert property ((standby || full_power_down) && $past(standby || full_power_down) |-> !output_enable)
        else $error("Enabled in power-down");
    oe_reset_a: assert property (!internal_reset_n |-> !output_enable)
        else $error("Enabled in reset");
    loss_off_a: assert property (idle_reg == 8'h6E && internal_reset_n |-> full_power_down)
        else $error("Clock loss missed");
    loss_clear_a: assert property (full_power_down && $past(full_power_down) |-> !low_emission && !half_pulse && !mode_32k)
        else $error("Modes kept after loss");
    rate_decim_a: assert property ($changed(rate_128) || $changed(decim_128) |-> rate_128 == decim_128)
        else $error("Filter differs from rate");
    link_half_a: assert property ($changed(bit_clk) |=> $stable(bit_clk) [*3])
        else $error("Half period too short");
    smart_only_a: assert property ($rose(standby) |-> smart_pd_enable)
        else $error("Standby without smart mode");
    cover property (standby);
    cover property (full_power_down);
    cover property (mute);
    cover property (gain_sel == pdm_ctrl_pkg::GAIN_2V5);
endmodule : pdm_link_props

// File: sim/pdm_pattern_power_control_tb.sv
// Bench joining source and amplifier control over one link.
// Assumes 50 MHz aclk; software reaches the source over AXI4-Lite.
`timescale 1ns/1ps
module pdm_pattern_power_control_tb;
    logic aclk = 1'h0, aresetn = 1'h0, ps_ok = 1'h1, smart = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
    logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid, vdd_ok = 1'h1;
    logic irst_n, r128, d128, lemi, hpls, m32, mute, stby, pdn, oe;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    pdm_ctrl_pkg::gain_t gain;
    int num_errors = 0, checks = 0, cyc = 0;
    pdm_link_if link ();
    always #10 aclk = ~aclk;
    pdm_source_ctrl u_pdm_source_ctrl (.aclk(aclk), .aresetn(aresetn), .link(link), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    pdm_amp_ctrl #(.STARTUP_LIMIT(16'h0014)) u_pdm_amp_ctrl (.aclk(aclk), .aresetn(aresetn), .link(link),
        .power_stage_supply_ok(ps_ok), .logic_supply_ok(vdd_ok), .gain_rate_strap_high(1'h1),
        .gain_rate_strap_weak(1'h0), .channel_side_strap(1'h0), .smart_pd_enable(smart),
        .internal_reset_n(irst_n), .gain_sel(gain), .rate_128(r128), .decim_128(d128), .low_emission(lemi),
        .half_pulse(hpls), .mode_32k(m32), .mute(mute), .standby(stby), .full_power_down(pdn),
        .output_enable(oe), .audio_bit(), .audio_valid());
    pdm_link_props u_props (.aclk(aclk), .aresetn(aresetn), .bit_clk(link.bit_clk), .data(link.data),
        .smart_pd_enable(smart), .internal_reset_n(irst_n), .gain_sel(gain), .rate_128(r128),
        .decim_128(d128), .low_emission(lemi), .half_pulse(hpls), .mode_32k(m32), .mute(mute),
        .standby(stby), .full_power_down(pdn), .output_enable(oe));
    task automatic give_verdict;
        $display("Counts: checks=%0d mismatches=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=0x%h exp=0x%h", $time, got, exp);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
    endtask : axi_rd
    task automatic send_pat(input logic [8:0] p);
        axi_wr(pdm_ctrl_pkg::REG_CMD, {23'h0, p});
        repeat (400) @(posedge aclk);
        chk({7'h0, mute}, 8'h01);
        do axi_rd(pdm_ctrl_pkg::REG_STATUS);
        while (rdata[31:pdm_ctrl_pkg::STAT_CNT_LSB] < 16'h0082);
        repeat (200) @(posedge aclk);
    endtask : send_pat
    task automatic test_patterns;
        logic [7:0] pat [7] = '{8'hD8, 8'hD4, 8'hD2, 8'hD1, 8'hE1, 8'hE2, 8'hE4};
        logic [7:0] exp [7] = '{8'h00, 8'h20, 8'h40, 8'h58, 8'h5C, 8'h5E, 8'h5F};
        for (int i = 0; i < 7; i++) begin
            send_pat({1'h0, pat[i]});
            chk({1'h0, gain, r128, d128, lemi, hpls, m32}, exp[i]);
        end
        $display("Test patterns done");
    endtask : test_patterns
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        chk({5'h0, gain, r128}, 8'h02);
        axi_rd(8'h40);
        chk({6'h0, rresp}, {6'h0, pdm_ctrl_pkg::RESP_SLVERR});
        axi_rd(pdm_ctrl_pkg::REG_AUDIO);
        chk(rdata[7:0], pdm_ctrl_pkg::AUDIO_RST);
        axi_wr(pdm_ctrl_pkg::REG_CTRL, 32'h1);
        test_patterns();
        smart <= 1'h1;
        send_pat({1'h1, pdm_ctrl_pkg::PAT_STOP});
        chk({6'h0, stby, oe}, 8'h02);
        axi_wr(pdm_ctrl_pkg::REG_CTRL, 32'h0);
        repeat (300) @(posedge aclk);
        chk({pdn, gain, r128, d128, lemi, hpls, m32}, 8'hA0);
        axi_wr(pdm_ctrl_pkg::REG_CMD, 32'h0);
        axi_wr(pdm_ctrl_pkg::REG_CTRL, 32'h1);
        repeat (300) @(posedge aclk);
        chk({6'h0, stby, pdn}, 8'h00);
        $display("Test power-down done");
        vdd_ok <= 1'h0;
        repeat (6) @(posedge aclk);
        chk({6'h0, irst_n, oe}, 8'h00);
        vdd_ok <= 1'h1;
        repeat (6) @(posedge aclk);
        chk({7'h0, irst_n}, 8'h01);
        ps_ok <= 1'h0;
        repeat (6) @(posedge aclk);
        chk({6'h0, irst_n, oe}, 8'h00);
        $display("Test supply done");
        give_verdict();
    end
endmodule : pdm_pattern_power_control_tb
